// File: dv/tmwg_pin_model.sv
/*
  port pin model behind the block: weak pull-up on a released pin.
  assumes pin_oe_n_i is low while the block drives the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tmwg_pin_model (
  input wire logic [1:0] pin_out_i,
  input wire logic [1:0] pin_oe_n_i,
  output logic [1:0] pin_lvl_o
);
  // ==========================================================================
  // pin level: the driven value only while direction is output, else pull-up
  assign pin_lvl_o = (~pin_oe_n_i & pin_out_i) | pin_oe_n_i;
endmodule // tmwg_pin_model
`default_nettype wire

// File: dv/tmwg_props.sv
/*
  checker of tmwg_top ports: bus answer, pin override, pin enables.
  assumes bind into tmwg_top, one clock, async active-high reset.
*/
`timescale 1ns/1ps
`include "tmwg_cfg.svh"
`default_nettype none
module tmwg_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] pin_out_o,
  input wire logic [1:0] pin_oe_n_o
);
  // ==========================================================================
  // data phase tracker; shadow {port data, clock select, actions b, a}
  logic dp_r, dp_nxt, wr_r, wr_nxt, wdp, rdp, pw;
  logic [7:0] ad_r, ad_nxt;
  logic [8:0] sh_r, sh_nxt;
  always_comb begin
    dp_nxt = hsel_i && hready_i && htrans_i[1];
    wr_nxt = hwrite_i;
    ad_nxt = haddr_i[7:0];
    sh_nxt = sh_r;
    if (wdp && ad_r == `TMWG_OFF_CTRL) begin
      sh_nxt[6:0] = {hwdata_i[6:4], hwdata_i[11:8]};
    end
    if (pw) begin
      sh_nxt[8:7] = hwdata_i[1:0];
    end
  end
  assign wdp = dp_r && wr_r;
  assign rdp = dp_r && !wr_r;
  assign pw = wdp && ad_r == `TMWG_OFF_PORT;
  // shadow lands on the same edge as the device register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dp_r <= 1'b0;
      wr_r <= 1'b0;
      ad_r <= 8'h00;
      sh_r <= 9'h000;
    end else begin
      dp_r <= dp_nxt;
      wr_r <= wr_nxt;
      ad_r <= ad_nxt;
      sh_r <= sh_nxt;
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ready_high: assert property (hreadyout_o)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_o)
    else $error("response not okay");
  a_dir_follow: assert property (
    pw |=> pin_oe_n_o == ~$past(hwdata_i[3:2]))
    else $error("enable does not follow direction");
  a_dir_cause: assert property ($changed(pin_oe_n_o) |-> $past(pw))
    else $error("enable moved without port write");
  a_pass_a: assert property (
    sh_r[1:0] == 2'b00 |-> pin_out_o[0] == sh_r[7])
    else $error("pin a not port data");
  a_pass_b: assert property (
    sh_r[3:2] == 2'b00 |-> pin_out_o[1] == sh_r[8])
    else $error("pin b not port data");
  a_ctrl_rsvd: assert property (
    rdp && ad_r == `TMWG_OFF_CTRL |-> hrdata_o[31:12] == 20'h00000)
    else $error("strobe bits read back");
  a_stop_hold: assert property (
    sh_r[6:4] == 3'b000 && $past(sh_r[6:4]) == 3'b000 && !wdp
    |=> $stable(pin_out_o)) else $error("pin moved while stopped");
  a_reset_pins: assert property (
    $fell(rst_i) |-> pin_out_o == 2'b00 && pin_oe_n_o == 2'b11)
    else $error("pins not at reset level");
  c_port_wr: cover property (pw);
  c_pin_a_move: cover property ($changed(pin_out_o[0]));
  c_pin_b_move: cover property ($changed(pin_out_o[1]));
endmodule // tmwg_props
bind tmwg_top tmwg_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));
`default_nettype wire

// File: dv/tmwg_top_tb.sv
/*
  testbench of tmwg_top: ahb-lite master tasks, pin model, scenarios.
  assumes tmwg_props is bound to the design; clock 40 MHz.
*/
`timescale 1ns/1ps
`include "tmwg_cfg.svh"
`default_nettype none
module tmwg_top_tb;
  logic clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, st;
  logic [1:0] htrans_i, pin_out_o, pin_oe_n_o, pin_lvl;
  logic [2:0] hsize_i;
  logic [7:0] c0;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rv;
  logic [31:0] seed = 32'h0000EF15; // fixed start 61205
  logic [1:0] acts [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
  int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  int miscompares = 0;
  int compares = 0;
  int n, lv, k, c, t;
  tmwg_top dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));
  tmwg_pin_model u_pin (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
    .pin_lvl_o(pin_lvl));
  // ==========================================================================
  // clock, helpers and bus tasks
  always #12.5 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // length of a pwm phase at a level; action 2 is high from bottom to match
  function automatic int exp_len(input int act, cmp, top, lvl);
    if ((act == 2) == (lvl == 1)) return cmp + 1;
    return top - cmp;
  endfunction
  function automatic logic st_after(input logic [1:0] act, input logic s);
    return (act == 2'h0) ? s : (act == 2'h1) ? ~s : act[0];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one single transfer; request held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] q);
    hsel_i <= 1'b1;
    haddr_i <= {24'h000000, a};
    htrans_i <= 2'b10;
    hwrite_i <= w;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rv);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h00000000, rv);
  endtask
  // waits for a pin edge, then counts cycles of the next phase (capped)
  task automatic span(input int b, output int len, output int lvl);
    logic v;
    len = 0;
    v = pin_lvl[b];
    while (pin_lvl[b] === v && len < 3000) begin
      @(posedge clk_i);
      len++;
    end
    v = pin_lvl[b];
    len = 0;
    while (pin_lvl[b] === v && len < 3000) begin
      @(posedge clk_i);
      len++;
    end
    lvl = int'(v);
  endtask
  // ==========================================================================
  // watchdog: the sequence needs some 15000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end
  // main sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = 32'h00000000;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hsize_i = 3'b010;
    hwdata_i = 32'h00000000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a <= 24; a += 4) begin
      rd(8'(a));
      chk(rv, 32'h00000000);
    end
    chk(32'(pin_oe_n_o), 32'h00000003);
    wr(`TMWG_OFF_PORT, 32'h0000000E);
    // force strobe with each action, timer stopped
    st = 1'b0;
    foreach (acts[i]) begin
      wr(`TMWG_OFF_CTRL, 32'h00001000 | (32'(acts[i]) << 8));
      st = st_after(acts[i], st);
      rd(`TMWG_OFF_STAT);
      chk(32'(rv[3]), 32'(st));
      chk(32'(pin_lvl[0]), 32'(acts[i] != 2'h0 && st));
    end
    // every prescaler tap: two ticks over twice the division
    for (int cs = 1; cs < 8; cs++) begin
      wr(`TMWG_OFF_CTRL, 32'(cs) << 4);
      rd(`TMWG_OFF_COUNT);
      c0 = rv[7:0];
      repeat (2 * divs[cs] - 2) @(posedge clk_i);
      rd(`TMWG_OFF_COUNT);
      chk(32'(8'(rv[7:0] - c0)), 32'h00000002);
    end
    // overflow in normal mode: set on wrap only, never cleared by hardware
    wr(`TMWG_OFF_CTRL, 32'h00000010);
    wr(`TMWG_OFF_STAT, 32'h00000007);
    wr(`TMWG_OFF_COUNT, 32'h00000080);
    rd(`TMWG_OFF_STAT);
    chk(32'(rv[0]), 32'h00000000);
    wr(`TMWG_OFF_COUNT, 32'h000000F0);
    repeat (30) @(posedge clk_i);
    rd(`TMWG_OFF_STAT);
    chk(32'(rv[0]), 32'h00000001);
    repeat (100) @(posedge clk_i);
    rd(`TMWG_OFF_STAT);
    chk(32'(rv[0]), 32'h00000001);
    // clear on match with a random top and toggle on channel a
    seed = xs(seed);
    k = 3 + int'(seed % 40);
    wr(`TMWG_OFF_CTRL, 32'h00000002);
    wr(`TMWG_OFF_CMPA, 32'(k));
    wr(`TMWG_OFF_COUNT, 32'h00000000);
    wr(`TMWG_OFF_STAT, 32'h00000007);
    wr(`TMWG_OFF_CTRL, 32'h00000112);
    span(0, n, lv);
    chk(32'(n), 32'(k + 1));
    rd(`TMWG_OFF_STAT);
    chk(32'(rv[1]), 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      rd(`TMWG_OFF_COUNT);
      chk(32'(rv <= 32'(k)), 32'h00000001);
    end
    // count above the compare in mode 2: no match until the count wraps
    wr(`TMWG_OFF_COUNT, 32'h00000050);
    wr(`TMWG_OFF_STAT, 32'h00000007);
    rd(`TMWG_OFF_STAT);
    chk(32'(rv[1:0]), 32'h00000000);
    repeat (300) @(posedge clk_i);
    rd(`TMWG_OFF_STAT);
    chk(32'(rv[1:0]), 32'h00000003);
    // fast pwm, top at max: random, bottom and max compare, both polarities
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      c = (i == 2) ? 0 : (i == 3) ? 255 : 1 + int'(seed % 200);
      wr(`TMWG_OFF_CMPA, 32'(c));
      wr(`TMWG_OFF_CTRL, 32'h00000013 | (32'(2 + i % 2) << 8));
      repeat (600) @(posedge clk_i);
      span(0, n, lv);
      chk(32'(n), 32'(c == 255 ? 3000 : exp_len(2 + i % 2, c, 255, lv)));
    end
    // overflow and match a both come around once per fast pwm period
    wr(`TMWG_OFF_STAT, 32'h00000007);
    repeat (300) @(posedge clk_i);
    rd(`TMWG_OFF_STAT);
    chk(32'(rv[1:0]), 32'h00000003);
    // fast pwm, top at compare a: b clears on match, a toggles at top
    seed = xs(seed);
    t = 20 + int'(seed % 40);
    wr(`TMWG_OFF_CMPA, 32'(t));
    wr(`TMWG_OFF_CMPB, 32'(t / 2));
    wr(`TMWG_OFF_CTRL, 32'h00000917);
    repeat (600) @(posedge clk_i);
    span(1, n, lv);
    chk(32'(n), 32'(exp_len(2, t / 2, t, lv)));
    span(0, n, lv);
    chk(32'(n), 32'(t + 1));
    end_sim();
  end
endmodule // tmwg_top_tb
`default_nettype wire

// File: rtl/tmwg_cfg.svh
/*
  constants for the timer8 waveform generator: register offsets, field
  positions, reset values and the prescaler divider width.
  assumes it is included by bare name from rtl files.
*/
`ifndef TMWG_CFG_SVH
`define TMWG_CFG_SVH

// ==========================================================================
// register byte offsets
`define TMWG_OFF_CTRL 8'h00
`define TMWG_OFF_COUNT 8'h04
`define TMWG_OFF_CMPA 8'h08
`define TMWG_OFF_CMPB 8'h0C
`define TMWG_OFF_STAT 8'h10
`define TMWG_OFF_PORT 8'h14

// ==========================================================================
// control register fields
`define TMWG_CTRL_WGM_LSB 0
`define TMWG_CTRL_CS_LSB 4
`define TMWG_CTRL_COMA_LSB 8
`define TMWG_CTRL_COMB_LSB 10
`define TMWG_CTRL_FOCA_BIT 12
`define TMWG_CTRL_FOCB_BIT 13

// status register fields (flag bits write one to clear; output state bits read only)
`define TMWG_STAT_TOV_BIT 0
`define TMWG_STAT_OCFA_BIT 1
`define TMWG_STAT_OCFB_BIT 2
`define TMWG_STAT_OCA_BIT 3
`define TMWG_STAT_OCB_BIT 4

// port register fields: data bits 1:0, direction bits 3:2
`define TMWG_PORT_DIR_LSB 2

// ==========================================================================
// reset value and counter bounds
`define TMWG_RST_BYTE 8'h00
`define TMWG_MAX 8'hFF
`define TMWG_BOTTOM 8'h00

// prescaler divider width (1024 needs ten bits)
`define TMWG_PRE_W 10

`endif

// File: rtl/tmwg_pkg.sv
/*
  types for the timer8 waveform generator.
  assumes nothing beyond a SystemVerilog compiler.
*/
package tmwg_pkg;
  // ========================================================================
  // waveform select codes
  typedef enum logic [2:0] {
    TMWG_NORMAL = 3'b000,
    TMWG_PCPWM = 3'b001,
    TMWG_CLEAR_ON_MATCH = 3'b010,
    TMWG_FAST_FF = 3'b011,
    TMWG_RSV4 = 3'b100,
    TMWG_PCPWM_A = 3'b101,
    TMWG_RSV6 = 3'b110,
    TMWG_FAST_A = 3'b111
  } tmwg_wave_type;

  // output action codes
  typedef enum logic [1:0] {
    TMWG_ACT_NONE = 2'b00,
    TMWG_ACT_TOGGLE = 2'b01,
    TMWG_ACT_CLEAR = 2'b10,
    TMWG_ACT_SET = 2'b11
  } tmwg_action_type;

  // bus slave phase
  typedef enum logic [0:0] {
    TMWG_BUS_IDLE = 1'b0,
    TMWG_BUS_DATA = 1'b1
  } tmwg_bus_type;
endpackage

// File: rtl/tmwg_top.sv
/*
  timer8 waveform generator: 8-bit counter with prescaler, two compare
  channels, normal / clear-on-match / fast pwm sequencing, flags (match flags at clock select 1 only) and the
  port pin override, reached over an ahb-lite slave.
  assumes one clock domain, single word transfers and an okay-only bus.
*/
`timescale 1ns/1ps
`include "tmwg_cfg.svh"
`default_nettype none

module tmwg_top #(
  parameter int CNT_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_n_o
);

  // ========================================================================
  // elaboration check: the compare logic is built for a byte counter
  if (CNT_W != 8) begin : g_bad_width
    $error("tmwg_top serves only an 8-bit counter");
  end
  // the top prescaler tap compares all ten divider bits
  if (`TMWG_PRE_W != 10) begin : g_bad_pre
    $error("tmwg_top needs a ten-bit prescaler divider");
  end

  // ========================================================================
  // bus slave state
  tmwg_pkg::tmwg_bus_type bus_r, bus_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic wr_r, wr_nxt;

  // control and data registers
  logic [2:0] wave_r, wave_nxt;
  logic [2:0] clk_sel_r, clk_sel_nxt;
  logic [1:0] act_a_r, act_a_nxt;
  logic [1:0] act_b_r, act_b_nxt;
  logic [7:0] count_r, count_nxt;
  logic [7:0] cmp_buf_r [2];
  logic [7:0] cmp_buf_nxt [2];
  logic [7:0] cmp_r [2];
  logic [7:0] cmp_nxt [2];
  logic ovf_r, ovf_nxt;
  logic [1:0] mflag_r, mflag_nxt;
  logic [1:0] ostate_r, ostate_nxt;
  logic [1:0] pdata_r, pdata_nxt;
  logic [1:0] pdir_r, pdir_nxt;
  logic [1:0] mpend_r, mpend_nxt;
  logic blk_r, blk_nxt;
  logic [`TMWG_PRE_W-1:0] pre_r, pre_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] pin_r, pin_nxt;
  logic [1:0] oen_r, oen_nxt;

  // decoded helpers
  logic wr_go, tick, is_pwm, is_fast;
  logic [7:0] top_val;
  logic [1:0] act [2];
  logic [1:0] force_s;
  logic [1:0] fact [2];
  logic ovf_set;
  logic [1:0] hit;

  // ========================================================================
  // prescaler tap: the timer clock enable is one io-clock cycle wide
  // the divider runs free, so the first tick after a select change may
  // come early by up to one division; no phase reset is offered
  always_comb begin
    pre_nxt = pre_r + 1'b1;
    case (clk_sel_r)
      3'd1: tick = 1'b1;
      3'd2: tick = (pre_r[2:0] == 3'h7);
      3'd3: tick = (pre_r[4:0] == 5'h1F);
      3'd4: tick = (pre_r[5:0] == 6'h3F);
      3'd5: tick = (pre_r[6:0] == 7'h7F);
      3'd6: tick = (pre_r[7:0] == 8'hFF);
      3'd7: tick = (pre_r == 10'h3FF);
      default: tick = 1'b0;                                // stopped
    endcase
  end

  // ========================================================================
  // mode decode: only the waveform select shapes the count sequence
  // phase-correct and reserved codes simply count up like normal mode
  always_comb begin
    is_fast = (wave_r == tmwg_pkg::TMWG_FAST_FF) ||
              (wave_r == tmwg_pkg::TMWG_FAST_A);
    is_pwm = wave_r[0];
    top_val = (wave_r == tmwg_pkg::TMWG_FAST_A) ?
              cmp_r[0] : `TMWG_MAX;
    act[0] = act_a_r;
    act[1] = act_b_r;
    // a force takes the action written alongside it, not the old one
    fact[0] = hwdata_i[`TMWG_CTRL_COMA_LSB +: 2];
    fact[1] = hwdata_i[`TMWG_CTRL_COMB_LSB +: 2];
    // a count write blocks matches for one timer cycle
    hit[0] = (count_r == cmp_r[0]) && !blk_r;
    hit[1] = (count_r == cmp_r[1]) && !blk_r;
    wr_go = (bus_r == tmwg_pkg::TMWG_BUS_DATA) && wr_r;
    force_s[0] = wr_go && (addr_r == `TMWG_OFF_CTRL) &&
                 hwdata_i[`TMWG_CTRL_FOCA_BIT] && !is_pwm;
    force_s[1] = wr_go && (addr_r == `TMWG_OFF_CTRL) &&
                 hwdata_i[`TMWG_CTRL_FOCB_BIT] && !is_pwm;
  end

  // ========================================================================
  // counter, flags, compare buffers and output state
  always_comb begin
    count_nxt = count_r;
    ovf_nxt = ovf_r;
    mflag_nxt = mflag_r;
    ostate_nxt = ostate_r;
    mpend_nxt = 2'b00;
    ovf_set = 1'b0;
    blk_nxt = blk_r && !tick;
    for (int c = 0; c < 2; c++) begin
      cmp_buf_nxt[c] = cmp_buf_r[c];
      cmp_nxt[c] = is_pwm ? cmp_r[c] : cmp_buf_r[c];
    end
    if (tick) begin
      // sequence
      if (is_fast && count_r == top_val) begin
        count_nxt = `TMWG_BOTTOM;
        ovf_nxt = 1'b1;
        ovf_set = 1'b1;
        for (int c = 0; c < 2; c++) begin
          cmp_nxt[c] = cmp_buf_r[c];
        end
      end else if (wave_r == tmwg_pkg::TMWG_CLEAR_ON_MATCH &&
                   hit[0]) begin
        count_nxt = `TMWG_BOTTOM;
      end else begin
        count_nxt = count_r + 8'h01;
        // low compare in mode 2 misses and rides through the wrap
        if (count_r == `TMWG_MAX && !is_fast) begin
          ovf_nxt = 1'b1;
          ovf_set = 1'b1;
        end
      end
      // matches flag one cycle later only when clock select 1 ticks every cycle; waveform acts on the match
      for (int c = 0; c < 2; c++) begin
        mpend_nxt[c] = hit[c];
        if (hit[c]) begin
          case (act[c])
            tmwg_pkg::TMWG_ACT_TOGGLE: begin
              if (!is_pwm || (is_fast && c == 0)) begin
                ostate_nxt[c] = ~ostate_r[c];
              end
            end
            tmwg_pkg::TMWG_ACT_CLEAR: ostate_nxt[c] = 1'b0;
            tmwg_pkg::TMWG_ACT_SET: ostate_nxt[c] = 1'b1;
            default: ostate_nxt[c] = ostate_r[c];
          endcase
        end
        // bottom edge of fast pwm, skipped when compare equals top
        if (is_fast && count_r == top_val && !hit[c] && act[c][1]) begin
          ostate_nxt[c] = ~act[c][0];
        end
      end
    end
    // flag set from the match in the next io-clock cycle, only if that cycle ticks
    for (int c = 0; c < 2; c++) begin
      if (mpend_r[c] && tick) begin
        mflag_nxt[c] = 1'b1;
      end
    end
    if (wr_go) begin
      case (addr_r)
        `TMWG_OFF_COUNT: begin
          count_nxt = hwdata_i[7:0];
          blk_nxt = 1'b1;
        end
        `TMWG_OFF_CMPA: cmp_buf_nxt[0] = hwdata_i[7:0];
        `TMWG_OFF_CMPB: cmp_buf_nxt[1] = hwdata_i[7:0];
        `TMWG_OFF_STAT: begin
          // hardware set wins over a write-one clear, even when the flag
          // is already up, so a fresh overflow is never lost
          if (hwdata_i[`TMWG_STAT_TOV_BIT] && !ovf_set) begin
            ovf_nxt = 1'b0;
          end
          for (int c = 0; c < 2; c++) begin
            if (hwdata_i[`TMWG_STAT_OCFA_BIT + c] &&
                !(mpend_r[c] && tick)) begin
              mflag_nxt[c] = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // forced match moves only the output state; flags and count stay
    for (int c = 0; c < 2; c++) begin
      if (force_s[c]) begin
        case (fact[c])
          tmwg_pkg::TMWG_ACT_TOGGLE: ostate_nxt[c] = ~ostate_r[c];
          tmwg_pkg::TMWG_ACT_CLEAR: ostate_nxt[c] = 1'b0;
          tmwg_pkg::TMWG_ACT_SET: ostate_nxt[c] = 1'b1;
          default: ostate_nxt[c] = ostate_r[c];
        endcase
      end
    end
  end

  // ========================================================================
  // control fields and port bits written by software
  always_comb begin
    wave_nxt = wave_r;
    clk_sel_nxt = clk_sel_r;
    act_a_nxt = act_a_r;
    act_b_nxt = act_b_r;
    pdata_nxt = pdata_r;
    pdir_nxt = pdir_r;
    if (wr_go && addr_r == `TMWG_OFF_CTRL) begin
      wave_nxt = hwdata_i[`TMWG_CTRL_WGM_LSB +: 3];
      clk_sel_nxt = hwdata_i[`TMWG_CTRL_CS_LSB +: 3];
      act_a_nxt = hwdata_i[`TMWG_CTRL_COMA_LSB +: 2];
      act_b_nxt = hwdata_i[`TMWG_CTRL_COMB_LSB +: 2];
    end
    if (wr_go && addr_r == `TMWG_OFF_PORT) begin
      pdata_nxt = hwdata_i[1:0];
      pdir_nxt = hwdata_i[`TMWG_PORT_DIR_LSB +: 2];
    end
  end

  // ========================================================================
  // pin drive: override depends on the action field alone; the enable
  // follows the direction bit only, so a released pin floats to its pull
  always_comb begin
    pin_nxt[0] = (|act_a_nxt) ? ostate_nxt[0] : pdata_nxt[0];
    pin_nxt[1] = (|act_b_nxt) ? ostate_nxt[1] : pdata_nxt[1];
    oen_nxt = ~pdir_nxt;
  end

  // ========================================================================
  // ahb-lite slave: zero wait states, always okay
  // read data is captured in the address phase, so a read placed right
  // behind a write still sees the register as it stood before that write
  always_comb begin
    bus_nxt = tmwg_pkg::TMWG_BUS_IDLE;
    addr_nxt = addr_r;
    wr_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (hsel_i && hready_i && htrans_i[1]) begin
      bus_nxt = tmwg_pkg::TMWG_BUS_DATA;
      addr_nxt = haddr_i[7:0];
      wr_nxt = hwrite_i;
      rdata_nxt = 32'h0000_0000;
      case (haddr_i[7:0])
        `TMWG_OFF_CTRL: begin
          rdata_nxt[`TMWG_CTRL_WGM_LSB +: 3] = wave_r;
          rdata_nxt[`TMWG_CTRL_CS_LSB +: 3] = clk_sel_r;
          rdata_nxt[`TMWG_CTRL_COMA_LSB +: 2] = act_a_r;
          rdata_nxt[`TMWG_CTRL_COMB_LSB +: 2] = act_b_r;
        end
        `TMWG_OFF_COUNT: rdata_nxt[7:0] = count_r;
        `TMWG_OFF_CMPA: rdata_nxt[7:0] = cmp_buf_r[0];
        `TMWG_OFF_CMPB: rdata_nxt[7:0] = cmp_buf_r[1];
        `TMWG_OFF_STAT: begin
          rdata_nxt[`TMWG_STAT_TOV_BIT] = ovf_r;
          rdata_nxt[`TMWG_STAT_OCFA_BIT] = mflag_r[0];
          rdata_nxt[`TMWG_STAT_OCFB_BIT] = mflag_r[1];
          rdata_nxt[`TMWG_STAT_OCA_BIT] = ostate_r[0];
          rdata_nxt[`TMWG_STAT_OCB_BIT] = ostate_r[1];
        end
        `TMWG_OFF_PORT: begin
          rdata_nxt[1:0] = pdata_r;
          rdata_nxt[`TMWG_PORT_DIR_LSB +: 2] = pdir_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // state registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_r <= tmwg_pkg::TMWG_BUS_IDLE;
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      wave_r <= 3'h0;
      clk_sel_r <= 3'h0;
      act_a_r <= 2'h0;
      act_b_r <= 2'h0;
      count_r <= `TMWG_RST_BYTE;
      for (int c = 0; c < 2; c++) begin
        cmp_buf_r[c] <= `TMWG_RST_BYTE;
        cmp_r[c] <= `TMWG_RST_BYTE;
      end
      ovf_r <= 1'b0;
      mflag_r <= 2'h0;
      ostate_r <= 2'h0;
      pdata_r <= 2'h0;
      pdir_r <= 2'h0;
      mpend_r <= 2'h0;
      blk_r <= 1'b0;
      pre_r <= 10'h000;
      rdata_r <= 32'h0000_0000;
      pin_r <= 2'h0;
      oen_r <= 2'h3;
    end else begin
      bus_r <= bus_nxt;
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
      wave_r <= wave_nxt;
      clk_sel_r <= clk_sel_nxt;
      act_a_r <= act_a_nxt;
      act_b_r <= act_b_nxt;
      count_r <= count_nxt;
      cmp_buf_r <= cmp_buf_nxt;
      cmp_r <= cmp_nxt;
      ovf_r <= ovf_nxt;
      mflag_r <= mflag_nxt;
      ostate_r <= ostate_nxt;
      pdata_r <= pdata_nxt;
      pdir_r <= pdir_nxt;
      mpend_r <= mpend_nxt;
      blk_r <= blk_nxt;
      pre_r <= pre_nxt;
      rdata_r <= rdata_nxt;
      pin_r <= pin_nxt;
      oen_r <= oen_nxt;
    end
  end

  assign hrdata_o = rdata_r;
  // no wait states: every register answers in the cycle after its address
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign pin_out_o = pin_r;
  assign pin_oe_n_o = oen_r;

endmodule // tmwg_top

`default_nettype wire
